//--- hw/dmc_ctl.sv
/*
 DRAM channel control: mode field, exit initiator, channel hashing and
 addressing mode, with special-mode command translation.
 Assumes requests come from logic on aclk; AXI4-Lite slave for registers.
*/
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Reset clears the mode field to normal access.
// - Mode NOP turns every access into a NOP command.
// - Mode precharge turns every access into all-bank precharge.
// - Mode register-set turns every access into a mode register set.
// - During mode register set, access address drives DRAM address lines.
// - Extended mode turns accesses into extended mode register set.
// - Calibration mode issues initial ZQ calibration, for DDR3 only.
// - Refresh mode turns every access into a CBR refresh.
// - Exit-initiator bit: zero internal agent, one boot firmware.
// - Hash-disable zero mixes extra address bits into channel choice when the addressing bit is one.
// - Addressing bit: zero single or asymmetric, one interleaved.
// - Extended mode bank from two-bit selector; pattern three reserved.
// - Independent bit takes mode from each channel's own register.
module dmc_ctl #(
	parameter int HASH_LSB = 12,
	parameter int HASH_W   = 4
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [11:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [11:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire dmc_pkg::dmc_req_type  req,
	input  wire logic                  ddr3_attached,
	output dmc_pkg::dmc_dcmd_type      dcmd,
	output logic                       internal_exit_agent,
	output logic                       addressing_mode_ctl
);
	// Hash window must sit above the interleave bit and inside the address
	if (HASH_W < 1) begin : g_bad_width
		$error("dmc_ctl: hash width must be at least one");
	end
	if (HASH_LSB < 1 || HASH_LSB + HASH_W > 32) begin : g_bad_lsb
		$error("dmc_ctl: hash field out of range");
	end

	// ----------------------------------------------------------------
	// Register write channel
	// ----------------------------------------------------------------
	logic [31:0] ctl_r, ctl_nxt;
	logic [31:0] ch0_r, ch0_nxt;
	logic [31:0] ch1_r, ch1_nxt;
	logic        aw_r, aw_nxt;
	logic        w_r, w_nxt;
	logic [11:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0]  wstrb_r, wstrb_nxt;
	logic        bvalid_r, bvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic [31:0] bmask;
	logic        wr_go;

	// One write at a time: both channels stall while a response waits
	assign s_axi_awready = !aw_r && !bvalid_r;
	assign s_axi_wready  = !w_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] data, input logic [31:0] m);
		merge = (old & ~m) | (data & m);
	endfunction

	always_comb begin
		aw_nxt     = aw_r;
		w_nxt      = w_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt  = wdata_r;
		wstrb_nxt  = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		ctl_nxt    = ctl_r;
		ch0_nxt    = ch0_r;
		ch1_nxt    = ch1_r;
		bmask      = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
			{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
		if (s_axi_awvalid && s_axi_awready) begin
			aw_nxt     = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_nxt     = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (wr_go) begin
			aw_nxt     = 1'b0;
			w_nxt      = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = dmc_pkg::RESP_OKAY;
			// Unmapped offsets answer SLVERR and store nothing
			case (awaddr_r[11:2])
				dmc_pkg::CTL_OFFSET[11:2]: ctl_nxt = merge(ctl_r, wdata_r,
					bmask & dmc_pkg::CTL_WMASK);
				dmc_pkg::CH0_OFFSET[11:2]: ch0_nxt = merge(ch0_r, wdata_r,
					bmask & dmc_pkg::CH_WMASK);
				dmc_pkg::CH1_OFFSET[11:2]: ch1_nxt = merge(ch1_r, wdata_r,
					bmask & dmc_pkg::CH_WMASK);
				default: bresp_nxt = dmc_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
	end
	assign wr_go = aw_r && w_r && !bvalid_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_r    <= dmc_pkg::CTL_RESET;
			ch0_r    <= dmc_pkg::CTL_RESET;
			ch1_r    <= dmc_pkg::CTL_RESET;
			aw_r     <= 1'b0;
			w_r      <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r  <= 32'h00000000;
			wstrb_r  <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r  <= dmc_pkg::RESP_OKAY;
		end else begin
			ctl_r    <= ctl_nxt;
			ch0_r    <= ch0_nxt;
			ch1_r    <= ch1_nxt;
			aw_r     <= aw_nxt;
			w_r      <= w_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r  <= wdata_nxt;
			wstrb_r  <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r  <= bresp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register read channel
	// ----------------------------------------------------------------
	logic        rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;

	// Read word is held until taken, so a late rready sees the same value
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = dmc_pkg::RESP_OKAY;
			case (s_axi_araddr[11:2])
				dmc_pkg::CTL_OFFSET[11:2]: rdata_nxt = ctl_r;
				dmc_pkg::CH0_OFFSET[11:2]: rdata_nxt = ch0_r;
				dmc_pkg::CH1_OFFSET[11:2]: rdata_nxt = ch1_r;
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = dmc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= dmc_pkg::RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
			rresp_r  <= rresp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Memory type strap
	// ----------------------------------------------------------------
	// Strap comes from the board, so it crosses in through two flops
	logic d3_meta_r, d3_meta_nxt;
	logic d3_sync_r, d3_sync_nxt;

	always_comb begin
		d3_meta_nxt = ddr3_attached;
		d3_sync_nxt = d3_meta_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			d3_meta_r <= 1'b0;
			d3_sync_r <= 1'b0;
		end else begin
			d3_meta_r <= d3_meta_nxt;
			d3_sync_r <= d3_sync_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Channel selection and command translation
	// ----------------------------------------------------------------
	dmc_pkg::dmc_dcmd_type dcmd_r, dcmd_nxt;
	dmc_pkg::dmc_mode_type mode;
	logic [HASH_W-1:0]     hbits;
	logic                  hash;
	logic                  chan;
	logic [1:0]            bsel;

	// Extended mode selector counts up from bank one
	localparam logic [2:0] BANK_BASE = 3'h1;
	localparam logic [1:0] BSEL_RSVD = 2'h3;

	assign internal_exit_agent = !ctl_r[dmc_pkg::EXIT_BIT];
	assign addressing_mode_ctl = ctl_r[dmc_pkg::AMODE_BIT];
	assign bsel  = ctl_r[dmc_pkg::BANK_LSB +: 2];
	assign hbits = req.addr[HASH_LSB +: HASH_W];
	assign hash  = ^hbits;
	assign dcmd  = dcmd_r;

	always_comb begin
		// Interleave on the low line bit; hashing spreads pages
		if (!ctl_r[dmc_pkg::AMODE_BIT])
			chan = req.chan;
		else if (!ctl_r[dmc_pkg::HASH_BIT])
			chan = req.addr[HASH_LSB-1] ^ hash;
		else
			chan = req.addr[HASH_LSB-1];
		if (ctl_r[dmc_pkg::INDEP_BIT])
			mode = dmc_pkg::dmc_mode_type'(chan
				? ch1_r[dmc_pkg::MODE_LSB +: 3]
				: ch0_r[dmc_pkg::MODE_LSB +: 3]);
		else
			mode = dmc_pkg::dmc_mode_type'(ctl_r[dmc_pkg::MODE_LSB +: 3]);
		dcmd_nxt       = '0;
		dcmd_nxt.valid = req.valid;
		dcmd_nxt.chan  = chan;
		dcmd_nxt.cmd   = dmc_pkg::CMD_NONE;
		case (mode)
			dmc_pkg::MODE_NORMAL: begin
				dcmd_nxt.cmd   = dmc_pkg::CMD_ACCESS;
				dcmd_nxt.maddr = req.addr[15:0];
			end
			dmc_pkg::MODE_NOP:    dcmd_nxt.cmd = dmc_pkg::CMD_NOP;
			dmc_pkg::MODE_PRECHG: dcmd_nxt.cmd = dmc_pkg::CMD_PREA;
			dmc_pkg::MODE_MRS: begin
				dcmd_nxt.cmd   = dmc_pkg::CMD_MRS;
				dcmd_nxt.maddr = req.addr[15:0];
			end
			dmc_pkg::MODE_EMRS: begin
				dcmd_nxt.cmd   = dmc_pkg::CMD_EMRS;
				dcmd_nxt.maddr = req.addr[15:0];
				dcmd_nxt.bank  = {1'b0, bsel} + BANK_BASE;
				// Reserved bank pattern gives no command
				if (bsel == BSEL_RSVD)
					dcmd_nxt.cmd = dmc_pkg::CMD_NONE;
			end
			dmc_pkg::MODE_ZQCAL:
				// Calibration is a DDR3 command only
				dcmd_nxt.cmd = d3_sync_r ? dmc_pkg::CMD_ZQCL
					: dmc_pkg::CMD_NONE;
			dmc_pkg::MODE_REFRESH: dcmd_nxt.cmd = dmc_pkg::CMD_REF;
			default: dcmd_nxt.cmd = dmc_pkg::CMD_NONE;
		endcase
		if (!req.valid)
			dcmd_nxt = '0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			dcmd_r <= '0;
		else
			dcmd_r <= dcmd_nxt;
	end
endmodule
`default_nettype wire

//--- shared/dmc_pkg.sv
/*
 Shared constants and types for the DRAM channel control block.
 Assumes an AXI4-Lite master with 32-bit data on the register side.
*/
`default_nettype none
package dmc_pkg;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CTL_OFFSET  = 12'h200;
	localparam logic [ADDR_W-1:0] CH0_OFFSET  = 12'h210;
	localparam logic [ADDR_W-1:0] CH1_OFFSET  = 12'h214;
	localparam logic [31:0] CTL_RESET = 32'h00000000;
	localparam logic [31:0] CTL_WMASK = 32'h1F7F8402;
	localparam logic [31:0] CH_WMASK  = 32'h00070000;
	localparam int MODE_LSB = 16;
	localparam int BANK_LSB = 21;
	localparam int INDEP_BIT = 20;
	localparam int EXIT_BIT = 15;
	localparam int HASH_BIT = 10;
	localparam int AMODE_BIT = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MODE_NORMAL  = 3'h0,
		MODE_NOP     = 3'h1,
		MODE_PRECHG  = 3'h2,
		MODE_MRS     = 3'h3,
		MODE_EMRS    = 3'h4,
		MODE_ZQCAL   = 3'h5,
		MODE_REFRESH = 3'h6,
		MODE_RSVD    = 3'h7
	} dmc_mode_type;

	typedef enum logic [2:0] {
		CMD_NONE, CMD_NOP, CMD_PREA, CMD_MRS, CMD_EMRS, CMD_ZQCL,
		CMD_REF, CMD_ACCESS
	} dmc_cmd_type;

	typedef struct packed {
		logic        valid;
		logic        chan;
		logic [31:0] addr;
	} dmc_req_type;

	typedef struct packed {
		logic        valid;
		logic        chan;
		dmc_cmd_type cmd;
		logic [2:0]  bank;
		logic [15:0] maddr;
	} dmc_dcmd_type;
endpackage
`default_nettype wire

//--- dv/dmc_dram_model.sv
/* DRAM device stand-in for dmc_ctl commands.
 Assumes dcmd arrives on aclk. */
`timescale 1ns/1ns
`default_nettype none
module dmc_dram_model (
	input  wire logic                  aclk,
	input  wire dmc_pkg::dmc_dcmd_type dcmd,
	output logic [15:0]                mr0
);
	logic [15:0] emr [4];
	initial mr0 = 16'h0000;
	// Only loads change state; NOP, precharge, refresh leave it
	always @(posedge aclk) begin
		if (dcmd.valid && dcmd.cmd == dmc_pkg::CMD_MRS) begin
			mr0 <= dcmd.maddr;
		end
		if (dcmd.valid && dcmd.cmd == dmc_pkg::CMD_EMRS) begin
			emr[dcmd.bank[1:0]] <= dcmd.maddr;
		end
	end
endmodule
`default_nettype wire

//--- dv/dmc_sva.sv
/* Port checker for dmc_ctl.
 Assumes it is bound to every dmc_ctl instance. */
`timescale 1ns/1ns
`default_nettype none
module dmc_sva (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  s_axi_bvalid,
	input wire dmc_pkg::dmc_req_type  req,
	input wire logic                  ddr3_attached,
	input wire dmc_pkg::dmc_dcmd_type dcmd,
	input wire logic                  internal_exit_agent,
	input wire logic                  addressing_mode_ctl
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst;
		disable iff (1'b0) !aresetn |=> dcmd == '0 && internal_exit_agent;
	endproperty
	property p_issue;
		req.valid |=> dcmd.valid;
	endproperty
	property p_idle;
		!req.valid |=> dcmd == '0;
	endproperty
	property p_mrs;
		dcmd.valid && dcmd.cmd == dmc_pkg::CMD_MRS |->
			dcmd.maddr == $past(req.addr[15:0]);
	endproperty
	property p_bank;
		dcmd.cmd == dmc_pkg::CMD_EMRS |-> dcmd.bank inside {3'h1, 3'h2, 3'h3};
	endproperty
	property p_zq;
		dcmd.cmd == dmc_pkg::CMD_ZQCL |-> $past(ddr3_attached, 3);
	endproperty
	property p_chan;
		req.valid && !addressing_mode_ctl |=> dcmd.chan == $past(req.chan);
	endproperty
	// Exit owner may only move with a completed write
	property p_exit;
		$past(aresetn) && !$rose(s_axi_bvalid) |-> $stable(internal_exit_agent);
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	a_issue: assert property (p_issue) else $error("no command");
	a_idle: assert property (p_idle) else $error("stray command");
	a_mrs: assert property (p_mrs) else $error("mrs address");
	a_bank: assert property (p_bank) else $error("emrs bank");
	a_zq: assert property (p_zq) else $error("zq without ddr3");
	a_chan: assert property (p_chan) else $error("channel");
	a_exit: assert property (p_exit) else $error("exit owner moved");
	c_mrs: cover property (dcmd.valid && dcmd.cmd == dmc_pkg::CMD_MRS);
	c_emrs: cover property (dcmd.valid && dcmd.cmd == dmc_pkg::CMD_EMRS);
	c_ref: cover property (dcmd.valid && dcmd.cmd == dmc_pkg::CMD_REF);
endmodule
bind dmc_ctl dmc_sva u_sva (.aclk, .aresetn, .s_axi_bvalid, .req,
	.ddr3_attached, .dcmd, .internal_exit_agent, .addressing_mode_ctl);
`default_nettype wire

//--- dv/dmc_ctl_tb_top.sv
/* Self-checking bench for dmc_ctl with a DRAM model.
 Assumes package, design, model and checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module dmc_ctl_tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, d3 = 1'b1, il = 1'b0, hx = 1'b1;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic awr, wr_, bv, arr, rv, iea, amc;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0, rs = 32'h0000004A, rd_, la;
	logic [1:0] br, rr;
	logic [15:0] mr0;
	logic [2:0] cm [8] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
	dmc_pkg::dmc_req_type req = '0;
	dmc_pkg::dmc_dcmd_type dc;
	logic [3:0] dq[$];
	logic [33:0] rq[$];
	int error_cnt = 0, checks_done = 0, cyc = 0;
	always #20 aclk = ~aclk;
	dmc_ctl dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .req,
		.ddr3_attached(d3), .dcmd(dc), .internal_exit_agent(iea),
		.addressing_mode_ctl(amc));
	dmc_dram_model mdl (.aclk, .dcmd(dc), .mr0);
	// ----
	// Tasks
	// ----
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d, checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] e = dmc_pkg::RESP_OKAY);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge aclk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr_) wv <= 1'b0;
			if (bry && bv) begin
				bry <= 1'b0;
				chk({32'h0, br}, {32'h0, e});
			end
		end while (awv || wv || bry);
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		rq.push_back(e);
		do begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'b0;
			if (rry && rv) rry <= 1'b0;
		end while (arv || rry);
	endtask
	// Back-to-back requests; hash model mirrors the chosen channel mix
	task automatic go(input logic [2:0] c, input logic ch, input int n);
		logic [31:0] a;
		repeat (n) begin
			a = xs();
			la = a;
			req <= '{1'b1, ch, a};
			dq.push_back({il ? a[11] ^ (hx & ^a[15:12]) : ch, c});
			@(posedge aclk);
		end
		req.valid <= 1'b0;
		@(posedge aclk);
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
		if (dc.valid)
			chk({30'h0, dc.chan, dc.cmd}, {30'h0, dq.pop_front()});
		if (rv && rry) chk({rr, rd_}, rq.pop_front());
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(dmc_pkg::CTL_OFFSET, {2'h0, dmc_pkg::CTL_RESET});
		foreach (cm[m]) begin
			wr(dmc_pkg::CTL_OFFSET, 32'(m) << 16);
			go(cm[m], m[0], 2);
		end
		wr(dmc_pkg::CTL_OFFSET, 32'h00030000);
		go(3'h3, 1'b0, 1);
		@(posedge aclk);
		chk({18'h0, mr0}, {18'h0, la[15:0]});
		d3 <= 1'b0;
		wr(dmc_pkg::CTL_OFFSET, 32'h00050000);
		go(3'h0, 1'b1, 1);
		for (int s = 0; s < 4; s++) begin
			wr(dmc_pkg::CTL_OFFSET, 32'h00040000 | (32'(s) << 21));
			go(s == 3 ? 3'h0 : 3'h4, 1'b0, 1);
		end
		wr(dmc_pkg::CTL_OFFSET, 32'hFFFFFFFF);
		rd(dmc_pkg::CTL_OFFSET, {2'h0, dmc_pkg::CTL_WMASK});
		chk({32'h0, iea, amc}, {32'h0, 2'b01});
		il = 1'b1;
		wr(dmc_pkg::CTL_OFFSET, 32'h00000002);
		go(3'h7, 1'b0, 4);
		hx = 1'b0;
		wr(dmc_pkg::CTL_OFFSET, 32'h00000402);
		go(3'h7, 1'b1, 4);
		il = 1'b0;
		wr(dmc_pkg::CH0_OFFSET, 32'h00010000);
		wr(dmc_pkg::CH1_OFFSET, 32'hFFFFFFFF);
		rd(dmc_pkg::CH1_OFFSET, {2'h0, dmc_pkg::CH_WMASK});
		wr(dmc_pkg::CTL_OFFSET, 32'h00100000);
		go(3'h1, 1'b0, 1);
		go(3'h0, 1'b1, 1);
		wr(12'h208, 32'hFFFFFFFF, dmc_pkg::RESP_SLVERR);
		rd(12'h204, {dmc_pkg::RESP_SLVERR, 32'h0});
		rd(dmc_pkg::CTL_OFFSET, {2'h0, 32'h00100000});
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(dmc_pkg::CTL_OFFSET, {2'h0, 32'h0});
		complete_run();
	end
endmodule
`default_nettype wire
